/* core/asc_conv_ctrl.sv */
// Converter control top: registers, sleep-started conversion, result and interrupt.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module asc_conv_ctrl (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire asc_pkg::asc_bus_type   bus,
  output logic [7:0]                  rdata,
  input  wire logic                   global_ie,
  input  wire logic                   irq_ack,
  input  wire asc_pkg::asc_sleep_type sleep_state,
  input  wire logic                   cpu_halted,
  input  wire logic                   comp_hi,
  output logic                        irq,
  output asc_pkg::asc_analog_type     analog
);

  // ********************************************************
  // State
  // ********************************************************
  // The whole block state lives in one record, so reset and update stay in
  // a single process. The fields fall into five groups: the control bits that
  // software sees, the held result and its read lock, the first-conversion and sleep bookkeeping,
  // the two comparator synchroniser stages, and registered copies of every output.
  // Keeping the outputs in the record means that each port comes from a flop.
  typedef struct packed {
    logic [7:0]              rdata;
    logic                    en;
    logic                    start;
    logic                    auto;
    logic                    done;
    logic                    ie;
    logic [2:0]              ps;
    logic [1:0]              ref_sel;
    logic                    lj;
    logic [3:0]              ch;
    logic [9:0]              res;
    logic                    hi_lock;
    logic                    first;
    logic                    halted_q;
    logic                    sleep_conv;
    logic                    sleep_ev;
    logic                    mask_sleep;
    logic                    comp_s1;
    logic                    comp_s2;
    logic                    irq;
    asc_pkg::asc_analog_type an;
  } asc_state_type;

  asc_state_type s_ff;
  asc_state_type nxt_s;

  // Wires between the control record and the two helper modules. The
  // sequencer owns the conversion timing; this level owns what software
  // sees and when it sees it.
  logic       tick;
  logic       sar_busy;
  logic       sar_done;
  logic       sar_sh;
  logic [9:0] sar_trial;
  logic [9:0] sar_result;
  logic       sleep_ok;
  logic       trigger;

  // Justification changes only the view and never the stored code, so
  // flipping the bit reshapes both bytes at once without a new conversion.
  // Byte view of the result, right or left justified.
  function automatic logic [7:0] res_byte(input logic [9:0] r, input logic lj,
                                          input logic hi);
    logic [15:0] w;
    w = lj ? {r, 6'h00} : {6'h00, r};
    res_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // ********************************************************
  // Converter clock and sequencer
  // ********************************************************
  // The prescaler is held at zero while the converter is off, so the first
  // tick after an enable always comes a full divided period later.
  asc_prescale u_prescale (
    .clk  (clk),
    .nrst (nrst),
    .run  (s_ff.en),
    .sel  (s_ff.ps),
    .tick (tick)
  );

  // The comparator reaches the sequencer only after both synchroniser stages.
  // Decisions lag the trial code by three clocks, so a divided period shorter
  // than four clocks gives wrong codes.
  asc_sar u_sar (
    .clk         (clk),
    .nrst        (nrst),
    .run         (s_ff.en),
    .tick        (tick),
    .go          (s_ff.start),
    .first       (s_ff.first),
    .comp        (s_ff.comp_s2),
    .busy        (sar_busy),
    .done        (sar_done),
    .sample_hold (sar_sh),
    .trial       (sar_trial),
    .result      (sar_result)
  );

  // ********************************************************
  // Sleep trigger
  // ********************************************************
  // Only the two quiet sleep states qualify; deeper states leave the enable alone.
  assign sleep_ok = (sleep_state == asc_pkg::ASC_SLP_IDLE) ||
                    (sleep_state == asc_pkg::ASC_SLP_NOISE);

  // The halt input is a level from the sleep controller. Looking for its
  // rising edge, not its level, keeps a CPU that stays halted, or one that
  // wakes for another reason, from starting a second conversion.
  // Every software prerequisite is checked here as well; if one is missing
  // the halt simply passes without a conversion.
  // A fresh halt edge is needed, so a woken CPU never re-arms by itself.
  assign trigger = cpu_halted && !s_ff.halted_q && sleep_ok
                   && s_ff.en && !s_ff.start && !sar_busy
                   && !s_ff.auto && s_ff.ie;

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb
  begin
    nxt_s          = s_ff;
    nxt_s.rdata    = asc_pkg::RESET_VAL;
    // Both synchroniser stages move every cycle; only the second one is read,
    // because the first may still be settling.
    nxt_s.comp_s1  = comp_hi;
    nxt_s.comp_s2  = s_ff.comp_s1;
    nxt_s.halted_q = cpu_halted;

    // Read data default to zero every cycle, so a reply stands for one cycle
    // only and an idle bus reads as zero. Reading the low result byte sets the
    // lock and reading the high byte releases it, which keeps the two halves
    // of one code together across a completion.
    // Register reads; the data stand for exactly the following cycle.
    if (bus.rd)
    begin
      case (bus.addr)
        asc_pkg::ADDR_RES_LO:
        begin
          nxt_s.rdata   = res_byte(s_ff.res, s_ff.lj, 1'b0);
          nxt_s.hi_lock = 1'b1;
        end
        asc_pkg::ADDR_RES_HI:
        begin
          nxt_s.rdata   = res_byte(s_ff.res, s_ff.lj, 1'b1);
          nxt_s.hi_lock = 1'b0;
        end
        asc_pkg::ADDR_CTRL:
        begin
          nxt_s.rdata = {s_ff.en, s_ff.start, s_ff.auto, s_ff.done, s_ff.ie, s_ff.ps};
        end
        asc_pkg::ADDR_SEL:
        begin
          nxt_s.rdata = {s_ff.ref_sel, s_ff.lj, 1'b0, s_ff.ch};
        end
        asc_pkg::ADDR_EVT:
        begin
          nxt_s.rdata = {6'h00, s_ff.sleep_ev, s_ff.done};
        end
        asc_pkg::ADDR_MASK:
        begin
          nxt_s.rdata = {6'h00, s_ff.mask_sleep, s_ff.ie};
        end
        default:
        begin
          nxt_s.rdata = asc_pkg::RESET_VAL;
        end
      endcase
    end

    // Register writes; flag clears here may be overridden by a set below.
    // Writes land on the next edge. The done flag is write-one-to-clear in
    // both the control and the event register; a written zero has no effect.
    // A start is only taken together with the enable bit.
    if (bus.wr)
    begin
      case (bus.addr)
        asc_pkg::ADDR_CTRL:
        begin
          nxt_s.en   = bus.wdata[asc_pkg::CTL_EN];
          nxt_s.auto = bus.wdata[asc_pkg::CTL_AUTO];
          nxt_s.ie   = bus.wdata[asc_pkg::CTL_IE];
          nxt_s.ps   = bus.wdata[2:0];
          // Each software start is one conversion in single mode.
          if (bus.wdata[asc_pkg::CTL_START] && bus.wdata[asc_pkg::CTL_EN])
          begin
            nxt_s.start = 1'b1;
          end
          if (bus.wdata[asc_pkg::CTL_DONE])
          begin
            nxt_s.done = 1'b0;
          end
          // Enabling the converter makes the next conversion the long one.
          if (bus.wdata[asc_pkg::CTL_EN] && !s_ff.en)
          begin
            nxt_s.first = 1'b1;
          end
        end
        asc_pkg::ADDR_SEL:
        begin
          nxt_s.ref_sel = bus.wdata[7:6];
          nxt_s.lj      = bus.wdata[asc_pkg::SEL_LJ];
          nxt_s.ch      = bus.wdata[3:0];
        end
        asc_pkg::ADDR_EVT:
        begin
          if (bus.wdata[asc_pkg::EVT_DONE])
          begin
            nxt_s.done = 1'b0;
          end
          if (bus.wdata[asc_pkg::EVT_SLEEP])
          begin
            nxt_s.sleep_ev = 1'b0;
          end
        end
        asc_pkg::ADDR_MASK:
        begin
          // The done interrupt enable is shared with bit three of control.
          nxt_s.ie         = bus.wdata[asc_pkg::EVT_DONE];
          nxt_s.mask_sleep = bus.wdata[asc_pkg::EVT_SLEEP];
        end
        default:
        begin
          // Writes to unmapped places are ignored.
          nxt_s.en = s_ff.en;
        end
      endcase
    end

    // The vector fetch clears the done flag.
    if (irq_ack)
    begin
      nxt_s.done = 1'b0;
    end

    // Halting in a quiet sleep state launches the armed conversion.
    // The conversion is tagged so that its completion also raises the
    // wake-up event bit.
    if (trigger)
    begin
      nxt_s.start      = 1'b1;
      nxt_s.sleep_conv = 1'b1;
    end

    // Completion: result, flag and start bit move in the same cycle.
    // The completion pulse is applied after every clear above, so a set
    // always wins over a clear in the same cycle. While the low-byte lock is
    // held the new code is dropped but the flag still sets, so software
    // still learns that a conversion finished.
    if (sar_done)
    begin
      if (!s_ff.hi_lock)
      begin
        nxt_s.res = sar_result;
      end
      nxt_s.done  = 1'b1;
      nxt_s.start = 1'b0;
      nxt_s.first = 1'b0;
      if (s_ff.sleep_conv)
      begin
        nxt_s.sleep_ev   = 1'b1;
        nxt_s.sleep_conv = 1'b0;
      end
    end

    // Turning the converter off ends any conversion in progress.
    // The sequencer sees the registered enable drop after this edge and goes idle on the next one.
    if (!nxt_s.en)
    begin
      nxt_s.start      = 1'b0;
      nxt_s.sleep_conv = 1'b0;
    end

    // The request is a level built from the next-state flags, so it rises
    // and falls on the same edge as the flags behind it and no stale request
    // outlives a clear.
    // Interrupt needs the local and the global enable; a wake-up irq fires
    // even if another source already woke the CPU.
    nxt_s.irq = global_ie && ((nxt_s.done && nxt_s.ie) ||
                (nxt_s.sleep_ev && nxt_s.mask_sleep));

    // Analog controls; selection is frozen while a conversion runs so the
    // sample is not disturbed by a write mid-conversion.
    // Limitation: a selection written during a conversion takes effect only
    // after that conversion completes.
    nxt_s.an.en          = s_ff.en;
    nxt_s.an.sample_hold = sar_sh;
    nxt_s.an.trial       = sar_trial;
    if (!sar_busy)
    begin
      nxt_s.an.channel = s_ff.ch;
      nxt_s.an.ref_sel = s_ff.ref_sel;
      // Reserved reference code 10 leaves the internal reference off.
      nxt_s.an.temp_en = (s_ff.ch == asc_pkg::TEMP_CH);
      nxt_s.an.bg_en   = (s_ff.ref_sel == asc_pkg::REF_INT) ||
                         (s_ff.ch == asc_pkg::BANDGAP_CH);
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  // Reset is synchronous: the record clears on the first edge with the reset
  // input low, and every output then reads zero.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Every output is a field of the registered record.
  assign rdata  = s_ff.rdata;
  assign irq    = s_ff.irq;
  assign analog = s_ff.an;

endmodule // asc_conv_ctrl

/* core/asc_pkg.sv */
// Shared constants and carrier types for the sleep-aware converter control block.
package asc_pkg;

  // ********************************************************
  // Register map and field layout
  // ********************************************************
  localparam logic [7:0] ADDR_RES_LO = 8'h78;
  localparam logic [7:0] ADDR_RES_HI = 8'h79;
  localparam logic [7:0] ADDR_CTRL   = 8'h7a;
  localparam logic [7:0] ADDR_SEL    = 8'h7c;
  localparam logic [7:0] ADDR_EVT    = 8'h7e;
  localparam logic [7:0] ADDR_MASK   = 8'h7f;

  localparam int CTL_EN    = 7;
  localparam int CTL_START = 6;
  localparam int CTL_AUTO  = 5;
  localparam int CTL_DONE  = 4;
  localparam int CTL_IE    = 3;
  localparam int EVT_DONE  = 0;
  localparam int EVT_SLEEP = 1;
  localparam int SEL_LJ    = 5;

  localparam logic [7:0] RESET_VAL   = 8'h00;
  localparam logic [3:0] TEMP_CH     = 4'h8;
  localparam logic [3:0] BANDGAP_CH  = 4'he;
  localparam logic [1:0] REF_EXT     = 2'h0;
  localparam logic [1:0] REF_AVCC    = 2'h1;
  localparam logic [1:0] REF_INT     = 2'h3;

  // ********************************************************
  // Conversion timing in converter clock ticks
  // ********************************************************
  localparam logic [4:0] CONV_NORM  = 5'h0d;
  localparam logic [4:0] CONV_FIRST = 5'h19;
  localparam logic [4:0] SH_NORM    = 5'h02;
  localparam logic [4:0] SH_FIRST   = 5'h0e;
  localparam logic [9:0] SAR_MSB    = 10'h200;

  // ********************************************************
  // Carrier types
  // ********************************************************
  typedef enum logic [2:0] {
    ASC_SLP_IDLE, ASC_SLP_NOISE, ASC_SLP_PDOWN, ASC_SLP_PSAVE, ASC_SLP_STBY, ASC_SLP_XSTBY
  } asc_sleep_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } asc_bus_type;

  typedef struct packed {
    logic       en;
    logic       sample_hold;
    logic [9:0] trial;
    logic [1:0] ref_sel;
    logic [3:0] channel;
    logic       temp_en;
    logic       bg_en;
  } asc_analog_type;

endpackage

/* core/asc_prescale.sv */
// Converter clock prescaler producing one tick per divided period.
`timescale 1ns/1ps
module asc_prescale (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } asc_ps_state_type;

  asc_ps_state_type s_ff;
  asc_ps_state_type nxt_s;

  // Division 2 for codes 0 and 1, else two to the power of the code.
  function automatic logic [6:0] div_limit(input logic [2:0] code);
    logic [7:0] d;
    d = 8'h01 << code;
    if (code == 3'h0)
    begin
      d = 8'h02;
    end
    div_limit = 7'(d - 8'h01);
  endfunction

  // ********************************************************
  // Counter, held in reset while the converter is off
  // ********************************************************
  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (!run)
    begin
      nxt_s.cnt = 7'h00;
    end
    else if (s_ff.cnt >= div_limit(sel))
    begin
      nxt_s.cnt  = 7'h00;
      nxt_s.tick = 1'b1;
    end
    else
    begin
      nxt_s.cnt = s_ff.cnt + 7'h01;
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

endmodule // asc_prescale

/* core/asc_sar.sv */
// Successive approximation sequencer driving the trial code of the converter.
`timescale 1ns/1ps
module asc_sar (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       go,
  input  wire logic       first,
  input  wire logic       comp,
  output logic            busy,
  output logic            done,
  output logic            sample_hold,
  output logic [9:0]      trial,
  output logic [9:0]      result
);

  typedef enum logic {SAR_IDLE, SAR_CONV} asc_sar_st_type;

  typedef struct packed {
    asc_sar_st_type st;
    logic [4:0]     step;
    logic           first;
    logic [9:0]     mask;
    logic [9:0]     trial;
    logic [9:0]     result;
    logic           done;
    logic           sh;
  } asc_sar_state_type;

  asc_sar_state_type s_ff;
  asc_sar_state_type nxt_s;

  // ********************************************************
  // Sequencer: sample, ten bit decisions, then the result
  // ********************************************************
  always_comb
  begin
    logic [4:0] ns;
    logic [4:0] hs;
    logic [4:0] last;
    logic [9:0] t;
    ns         = s_ff.step + 5'h01;
    hs         = s_ff.first ? asc_pkg::SH_FIRST : asc_pkg::SH_NORM;
    last       = (s_ff.first ? asc_pkg::CONV_FIRST : asc_pkg::CONV_NORM) - 5'h01;
    t          = s_ff.trial;
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (!run)
    begin
      // Switching the converter off aborts any conversion.
      nxt_s.st    = SAR_IDLE;
      nxt_s.sh    = 1'b0;
      nxt_s.mask  = 10'h000;
      nxt_s.trial = 10'h000;
    end
    else
    begin
      case (s_ff.st)
        SAR_IDLE:
        begin
          if (go && tick)
          begin
            nxt_s.st    = SAR_CONV;
            nxt_s.step  = 5'h00;
            nxt_s.first = first;
            nxt_s.sh    = 1'b1;
            nxt_s.mask  = 10'h000;
          end
        end
        SAR_CONV:
        begin
          if (tick)
          begin
            if (ns == hs)
            begin
              t          = asc_pkg::SAR_MSB;
              nxt_s.mask = asc_pkg::SAR_MSB;
              nxt_s.sh   = 1'b0;
            end
            else if (s_ff.mask != 10'h000)
            begin
              // A low comparator means the input sits below the trial level.
              if (!comp)
              begin
                t = t & ~s_ff.mask;
              end
              t          = t | (s_ff.mask >> 1);
              nxt_s.mask = s_ff.mask >> 1;
            end
            nxt_s.trial = t;
            nxt_s.step  = ns;
            if (ns == last)
            begin
              nxt_s.result = t;
              nxt_s.done   = 1'b1;
              nxt_s.st     = SAR_IDLE;
            end
          end
        end
        default:
        begin
          nxt_s.st = SAR_IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign busy        = (s_ff.st == SAR_CONV);
  assign done        = s_ff.done;
  assign sample_hold = s_ff.sh;
  assign trial       = s_ff.trial;
  assign result      = s_ff.result;

endmodule // asc_sar

/* tb/asc_comp_model.sv */
// Behavioural comparator standing for the analog converter front end.
`timescale 1ns/1ps
module asc_comp_model (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire asc_pkg::asc_analog_type analog,
  input  wire logic [9:0]              vin,
  output logic                         comp_hi
);
  logic flip_ff;

  // A powered-down comparator gives no valid answer, so it wanders each cycle.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      flip_ff <= 1'b0;
    else
      flip_ff <= ~flip_ff;
  end

  // The bench holds the input still during a conversion.
  assign comp_hi = analog.en ? (vin >= analog.trial) : flip_ff;
endmodule // asc_comp_model

/* tb/asc_conv_asserts.sv */
// Checker of port relations of the converter control block.
`timescale 1ns/1ps
module asc_conv_asserts (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire asc_pkg::asc_bus_type    bus,
  input wire logic [7:0]              rdata,
  input wire logic                    global_ie,
  input wire logic                    irq,
  input wire asc_pkg::asc_analog_type analog
);
  // ********************************************************
  // Port relations
  // ********************************************************
  logic mapped;

  // Decode of the six mapped places; anything else must read back as zero.
  assign mapped = bus.addr inside {asc_pkg::ADDR_RES_LO, asc_pkg::ADDR_RES_HI,
    asc_pkg::ADDR_CTRL, asc_pkg::ADDR_SEL, asc_pkg::ADDR_EVT, asc_pkg::ADDR_MASK};

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // A read request at one given place.
  sequence rd_s(logic [7:0] a);
    bus.rd && bus.addr == a;
  endsequence

  rdata_idle_a:
    assert property (!bus.rd |=> rdata == 8'h00) else $error("read data not idle");
  unmapped_zero_a:
    assert property (bus.rd && !mapped |=> rdata == 8'h00) else $error("unmapped read not zero");
  sel_reserved_a:
    assert property (rd_s(asc_pkg::ADDR_SEL) |=> !rdata[4]) else $error("reserved bit set");
  start_en_a:
    assert property (rd_s(asc_pkg::ADDR_CTRL) ##1 rdata[asc_pkg::CTL_START]
      |-> rdata[asc_pkg::CTL_EN]) else $error("start set without enable");
  irq_gate_a:
    assert property (irq |-> $past(global_ie)) else $error("irq without global enable");
  temp_sense_a:
    assert property (analog.temp_en == (analog.channel == asc_pkg::TEMP_CH))
      else $error("sensor enable wrong");
  ref_select_a:
    assert property (analog.bg_en == (analog.ref_sel == asc_pkg::REF_INT
      || analog.channel == asc_pkg::BANDGAP_CH)) else $error("bandgap enable wrong");
  enable_kept_a:
    assert property ($fell(analog.en) |-> $past(bus.wr) || $past(bus.wr, 2))
      else $error("converter switched off without a write");
endmodule // asc_conv_asserts

bind asc_conv_ctrl asc_conv_asserts u_asserts (.clk(clk), .nrst(nrst), .bus(bus),
  .rdata(rdata), .global_ie(global_ie), .irq(irq), .analog(analog));

/* tb/test_adc_sleep_conversion_and_result.sv */
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module test_adc_sleep_conversion_and_result;
  logic                    clk = 1'b0;
  logic                    nrst = 1'b0;
  asc_pkg::asc_bus_type    bus = '0;
  logic [7:0]              rdata;
  logic                    global_ie = 1'b1;
  logic                    irq_ack = 1'b0;
  asc_pkg::asc_sleep_type  sleep_state = asc_pkg::ASC_SLP_IDLE;
  logic                    cpu_halted = 1'b0;
  logic                    comp_hi;
  logic                    irq;
  asc_pkg::asc_analog_type analog;
  logic [9:0]              vin = 10'h000;
  int                      fails = 0;
  int                      cmp_count = 0;
  int                      cyc = 0;

  asc_conv_ctrl dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .global_ie(global_ie), .irq_ack(irq_ack), .sleep_state(sleep_state),
    .cpu_halted(cpu_halted), .comp_hi(comp_hi), .irq(irq), .analog(analog));
  asc_comp_model u_comp (.clk(clk), .nrst(nrst), .analog(analog), .vin(vin),
    .comp_hi(comp_hi));

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  // The whole run needs under 6000 cycles, so more than three times that means a hang.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  // ********************************************************
  // Bus and wait helpers
  // ********************************************************
  // Each helper returns just after a rising edge with nothing pending.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic irq_is(input logic e);
    @(negedge clk);
    `CHK("irq", e, irq)
    @(posedge clk);
  endtask

  // A first conversion needs 25 ticks of 8 clocks, so 600 is ample.
  task automatic wait_irq(output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 600 && !hit; i++)
    begin
      @(negedge clk);
      hit = (irq === 1'b1);
    end
    @(posedge clk);
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_reset();
    logic [7:0] d;
    // Outputs are read mid-cycle, away from the edge that updates them.
    @(negedge clk);
    `CHK("irq_rst", 1'b0, irq)
    `CHK("analog_rst", '0, analog)
    @(posedge clk);
    for (int a = 8'h78; a < 8'h80; a++)
    begin
      rd(a[7:0], d);
      `CHK("reg_rst", asc_pkg::RESET_VAL, d)
    end
    wr(8'h7b, 8'hff);
    rd(8'h7b, d);
    `CHK("unmapped", 8'h00, d)
  endtask

  task automatic t_sel();
    for (int r = 0; r < 4; r++)
    begin
      wr(asc_pkg::ADDR_SEL, {r[1:0], 6'h08});
      @(negedge clk);
      `CHK("ref", r[1:0], analog.ref_sel)
      `CHK("temp", 1'b1, analog.temp_en)
      `CHK("bg", (r == 3), analog.bg_en)
      @(posedge clk);
    end
  endtask

  task automatic t_conv(input logic [9:0] c, input logic lj);
    logic [7:0] d;
    logic hit;
    vin <= c;
    wr(asc_pkg::ADDR_SEL, {asc_pkg::REF_INT, lj, 5'h00});
    wr(asc_pkg::ADDR_CTRL, 8'hcb);
    rd(asc_pkg::ADDR_CTRL, d);
    `CHK("busy", 1'b1, d[asc_pkg::CTL_START])
    wait_irq(hit);
    `CHK("irq_done", 1'b1, hit)
    rd(asc_pkg::ADDR_CTRL, d);
    `CHK("start", 1'b0, d[asc_pkg::CTL_START])
    `CHK("done", 1'b1, d[asc_pkg::CTL_DONE])
    rd(asc_pkg::ADDR_RES_LO, d);
    `CHK("res_lo", lj ? {c[1:0], 6'h00} : c[7:0], d)
    rd(asc_pkg::ADDR_RES_HI, d);
    `CHK("res_hi", lj ? c[9:2] : {6'h00, c[9:8]}, d)
    wr(asc_pkg::ADDR_CTRL, 8'h9b);
    irq_is(1'b0);
  endtask

  task automatic t_gate();
    logic hit;
    global_ie <= 1'b0;
    wr(asc_pkg::ADDR_CTRL, 8'hcb);
    wait_irq(hit);
    `CHK("irq_gated", 1'b0, hit)
    global_ie <= 1'b1;
    @(posedge clk);
    irq_is(1'b1);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
    irq_is(1'b0);
  endtask

  task automatic t_sleep(input asc_pkg::asc_sleep_type s);
    logic [7:0] d;
    logic hit;
    logic arm;
    arm = (s == asc_pkg::ASC_SLP_IDLE || s == asc_pkg::ASC_SLP_NOISE);
    vin <= 10'h155;
    wr(asc_pkg::ADDR_CTRL, 8'h8b);
    wr(asc_pkg::ADDR_MASK, 8'h03);
    sleep_state <= s;
    cpu_halted <= 1'b1;
    if (s == asc_pkg::ASC_SLP_NOISE)
    begin
      // Another interrupt wakes the CPU while the conversion runs.
      repeat (10) @(posedge clk);
      cpu_halted <= 1'b0;
    end
    wait_irq(hit);
    `CHK("sleep_irq", arm, hit)
    rd(asc_pkg::ADDR_EVT, d);
    `CHK("sleep_evt", arm, d[asc_pkg::EVT_SLEEP])
    wr(asc_pkg::ADDR_EVT, 8'h01);
    irq_is(arm);
    wr(asc_pkg::ADDR_EVT, 8'h02);
    wr(asc_pkg::ADDR_CTRL, 8'h9b);
    repeat (300) @(posedge clk);
    rd(asc_pkg::ADDR_CTRL, d);
    `CHK("no_rearm", 1'b0, d[asc_pkg::CTL_START])
    `CHK("en_kept", 1'b1, d[asc_pkg::CTL_EN])
    irq_is(1'b0);
    cpu_halted <= 1'b0;
    @(posedge clk);
  endtask

  // A low-byte read holds the result until the high byte is read.
  task automatic t_lock();
    logic [7:0] d;
    logic hit;
    rd(asc_pkg::ADDR_RES_LO, d);
    vin <= 10'h155;
    wr(asc_pkg::ADDR_CTRL, 8'hcb);
    wait_irq(hit);
    `CHK("irq_locked", 1'b1, hit)
    rd(asc_pkg::ADDR_RES_HI, d);
    `CHK("res_locked", 8'hff, d)
    wr(asc_pkg::ADDR_CTRL, 8'h9b);
  endtask

  // With auto trigger selected the prerequisites fail and a halt starts nothing.
  task automatic t_auto();
    logic [7:0] d;
    wr(asc_pkg::ADDR_CTRL, 8'hab);
    sleep_state <= asc_pkg::ASC_SLP_IDLE;
    cpu_halted <= 1'b1;
    repeat (20) @(posedge clk);
    rd(asc_pkg::ADDR_CTRL, d);
    `CHK("auto_block", 1'b0, d[asc_pkg::CTL_START])
    cpu_halted <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: reset, then every scenario, t_conv three times and t_sleep once per sleep state.
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    t_reset();
    t_sel();
    t_conv(10'h2a5, 1'b0);
    t_conv(10'h000, 1'b0);
    t_conv(10'h3ff, 1'b1);
    t_lock();
    t_gate();
    t_auto();
    for (int s = 0; s < 6; s++)
      t_sleep(asc_pkg::asc_sleep_type'(s[2:0]));
    wr(asc_pkg::ADDR_CTRL, 8'h00);
    @(negedge clk);
    `CHK("en_off", 1'b0, analog.en)
    // Two more edges let the checker see the enable fall.
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule // test_adc_sleep_conversion_and_result
